// ---- core/pcs_sequencer.sv ----
// Program counter, return stack and indirect addressing with AXI4-Lite
`timescale 1ns/1ps
module pcs_sequencer #(
    parameter logic [pcs_pkg::PC_W-1:0] IRQ_VEC = pcs_pkg::IRQ_VECTOR
) (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // Register bus, write side
    input  wire logic [pcs_pkg::AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [pcs_pkg::AXI_DW-1:0]   s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    // Register bus, read side
    input  wire logic [pcs_pkg::AXI_AW-1:0]   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [pcs_pkg::AXI_DW-1:0]        s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // Execution core, one operation per cycle of exec_valid
    input  wire logic                         exec_valid,
    input  wire pcs_pkg::pcs_op_t             exec_op,
    input  wire logic [pcs_pkg::TGT_W-1:0]    exec_target,
    input  wire logic [pcs_pkg::BYTE_W-1:0]   exec_data,
    output logic [pcs_pkg::PC_W-1:0]          pc_addr,
    // Execution core, indirect data access
    input  wire logic                         ind_valid,
    input  wire logic                         ind_write,
    input  wire logic [pcs_pkg::BYTE_W-1:0]   ind_wdata,
    output logic [pcs_pkg::BYTE_W-1:0]        ind_rdata,
    output logic                              ind_done,
    // Data memory
    output logic [pcs_pkg::ADDR_W-1:0]        mem_addr,
    output logic                              mem_we,
    output logic                              mem_re,
    output logic [pcs_pkg::BYTE_W-1:0]        mem_wdata,
    input  wire logic [pcs_pkg::BYTE_W-1:0]   mem_rdata
);
    import pcs_pkg::*;

    // Block state, except the return stack, in one word
    typedef struct packed {
        logic [PC_W-1:0]    pc;         // Program counter
        logic [HI_W-1:0]    latch;      // pc_high_latch
        logic [BYTE_W-1:0]  pointer;    // file_select_pointer
        logic               bank;       // indirect_bank_bit
        logic               awready;    // Write address ready
        logic               wready;     // Write data ready
        logic               bvalid;     // Write response valid
        logic [1:0]         bresp;      // Write response code
        logic               arready;    // Read address ready
        logic               rvalid;     // Read data valid
        logic [1:0]         rresp;      // Read response code
        logic [AXI_DW-1:0]  rdata;      // Read data
        logic               aw_got;     // Write address held
        logic               w_got;      // Write data held
        logic [AXI_AW-1:0]  aw_addr;    // Held write address
        logic [BYTE_W-1:0]  wbyte;      // Held low data byte
        logic               wstrb0;     // Held low byte strobe
        logic [ADDR_W-1:0]  mem_addr;   // Resolved indirect address
        logic               mem_we;     // Memory write strobe
        logic               mem_re;     // Memory read strobe
        logic [BYTE_W-1:0]  mem_wdata;  // Memory write data
        logic               ind_pend;   // Indirect access in flight
        logic               ind_zero;   // Access selected the port
        logic               ind_done;   // Indirect answer pulse
        logic [BYTE_W-1:0]  ind_rdata;  // Indirect read result
    } pcs_top_state_t;

    pcs_top_state_t     state_reg;    // Registered state
    pcs_top_state_t     state_next;   // Next state
    logic               stk_push;     // Push request to stack
    logic               stk_pop;      // Pop request to stack
    logic [PC_W-1:0]    stk_wdata;    // Address to push
    logic [PC_W-1:0]    stk_top;      // Most recent return address

    // Return stack; its pointer has no path to the bus
    // eight deep stack
    pcs_ret_stack #(
        .DEPTH (STK_N),
        .W     (PC_W)
    ) u_stack (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .push      (stk_push),
        .pop       (stk_pop),
        .push_data (stk_wdata),
        .top_data  (stk_top)
    );

    // Stack control from the core operation
    always_comb
    begin
        stk_push  = 1'b0;
        stk_pop   = 1'b0;
        stk_wdata = state_reg.pc + 13'h0001;
        if (exec_valid)
        begin
            case (exec_op)
                OP_CALL: stk_push = 1'b1;
                OP_IRQ:
                begin
                    stk_push  = 1'b1;
                    stk_wdata = state_reg.pc;
                end
                OP_RET:  stk_pop  = 1'b1;
                default: stk_pop  = 1'b0;
            endcase
        end
    end

    // Next state for bus, counter and indirect path
    always_comb
    begin
        logic               aw_hs;     // Address taken now
        logic               w_hs;      // Data taken now
        logic               wr_go;     // Perform the write
        logic [AXI_AW-1:0]  wa;        // Address used by write
        logic [BYTE_W-1:0]  wb;        // Byte used by write
        logic               ws;        // Strobe used by write
        logic               sw_pcl;    // Software low byte write
        logic [ADDR_W-1:0]  eff;       // Indirect address
        aw_hs  = s_axi_awvalid & state_reg.awready;
        w_hs   = s_axi_wvalid & state_reg.wready;
        wa     = aw_hs ? s_axi_awaddr : state_reg.aw_addr;
        wb     = w_hs ? s_axi_wdata[BYTE_W-1:0] : state_reg.wbyte;
        ws     = w_hs ? s_axi_wstrb[0] : state_reg.wstrb0;
        wr_go  = 1'b0;
        sw_pcl = 1'b0;
        // bank bit on top of pointer
        eff    = {state_reg.bank, state_reg.pointer};
        state_next = state_reg;

        // Write channel capture, address and data in either order
        if (aw_hs)
        begin
            state_next.aw_got  = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (w_hs)
        begin
            state_next.w_got  = 1'b1;
            state_next.wbyte  = s_axi_wdata[BYTE_W-1:0];
            state_next.wstrb0 = s_axi_wstrb[0];
        end
        if (state_reg.bvalid && s_axi_bready)
            state_next.bvalid = 1'b0;

        // Both halves present: commit and answer
        if (state_next.aw_got && state_next.w_got && !state_reg.bvalid)
        begin
            wr_go              = 1'b1;
            state_next.aw_got  = 1'b0;
            state_next.w_got   = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = RESP_OKAY;
            case (wa)
                OFS_PC_LOW:  sw_pcl = ws;
                OFS_LATCH:
                    if (ws)
                        state_next.latch = wb[HI_W-1:0];
                OFS_POINTER:
                    if (ws)
                        state_next.pointer = wb;
                OFS_STATUS:
                    if (ws)
                        state_next.bank = wb[BANK_POS];
                default: state_next.bresp = RESP_DECERR;
            endcase
        end

        // Each ready only while its own channel holds nothing and no answer waits
        state_next.awready = !state_next.aw_got && !state_next.bvalid;
        state_next.wready  = !state_next.w_got && !state_next.bvalid;

        // Read channel
        if (state_reg.rvalid && s_axi_rready)
            state_next.rvalid = 1'b0;
        if (s_axi_arvalid && state_reg.arready)
        begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = RESP_OKAY;
            state_next.rdata  = '0;
            case (s_axi_araddr)
                OFS_PC_LOW:
                    state_next.rdata[BYTE_W-1:0] = state_reg.pc[7:0];
                OFS_LATCH:
                    state_next.rdata[HI_W-1:0] = state_reg.latch;
                OFS_POINTER:
                    state_next.rdata[BYTE_W-1:0] = state_reg.pointer;
                OFS_STATUS:
                    state_next.rdata[BANK_POS] = state_reg.bank;
                default: state_next.rresp = RESP_DECERR;
            endcase
        end
        state_next.arready = !state_next.rvalid;

        // Counter update; core operation takes priority over bus
        // latch untouched by stack traffic
        if (exec_valid)
        begin
            case (exec_op)
                // step by one, wraps at 13 bits
                OP_STEP:
                    state_next.pc = state_reg.pc + 13'h0001;
                OP_GOTO, OP_CALL:
                    state_next.pc = {state_reg.latch[PAGE_HI:PAGE_LO],
                                     exec_target};
                OP_RET:
                    state_next.pc = stk_top;
                // Vector to the interrupt entry
                OP_IRQ:
                    state_next.pc = IRQ_VEC;
                OP_PCL_WR:
                    state_next.pc = {state_reg.latch, exec_data};
                default:
                    state_next.pc = state_reg.pc;
            endcase
        end
        else if (sw_pcl && wr_go)
        begin
            state_next.pc = {state_reg.latch, wb};
        end

        // Indirect access, stage one: resolve and strobe memory
        // port itself holds no data
        state_next.mem_we   = 1'b0;
        state_next.mem_re   = 1'b0;
        state_next.ind_pend = 1'b0;
        state_next.ind_done = 1'b0;
        if (ind_valid)
        begin
            state_next.mem_addr  = eff;
            state_next.mem_wdata = ind_wdata;
            state_next.ind_pend  = 1'b1;
            state_next.ind_zero  = (state_reg.pointer == 8'h00);
            state_next.mem_we = ind_write &&
                                (state_reg.pointer != 8'h00);
            state_next.mem_re = !ind_write &&
                                (state_reg.pointer != 8'h00);
        end

        // Stage two: answer the core
        if (state_reg.ind_pend)
        begin
            state_next.ind_done = 1'b1;
            if (state_reg.ind_zero)
                state_next.ind_rdata = 8'h00;
            else if (state_reg.mem_re)
                state_next.ind_rdata = mem_rdata;
        end
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg         <= '0;
            state_reg.pc      <= RST_PC;
            state_reg.latch   <= RST_LATCH;
            state_reg.pointer <= RST_POINTER;
            state_reg.bank    <= RST_BANK;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready  = state_reg.wready;
    assign s_axi_bvalid  = state_reg.bvalid;
    assign s_axi_bresp   = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rresp   = state_reg.rresp;
    assign s_axi_rdata   = state_reg.rdata;
    assign pc_addr       = state_reg.pc;
    assign mem_addr      = state_reg.mem_addr;
    assign mem_we        = state_reg.mem_we;
    assign mem_re        = state_reg.mem_re;
    assign mem_wdata     = state_reg.mem_wdata;
    assign ind_rdata     = state_reg.ind_rdata;
    assign ind_done      = state_reg.ind_done;

endmodule // pcs_sequencer

// ---- core/pcs_pkg.sv ----
// Shared constants and types for the program sequencing block
package pcs_pkg;

    // Datapath widths
    localparam int PC_W     = 13;   // Program counter width
    localparam int BYTE_W   = 8;    // Data register width
    localparam int HI_W     = 5;    // Upper counter bits and latch width
    localparam int TGT_W    = 11;   // Branch target field width
    localparam int ADDR_W   = 9;    // Indirect data address width
    localparam int STK_N    = 8;    // Return stack depth
    localparam int AXI_AW   = 8;    // Register bus address width
    localparam int AXI_DW   = 32;   // Register bus data width

    // Field positions
    localparam int PAGE_HI  = 4;    // Top page select bit of the latch
    localparam int PAGE_LO  = 3;    // Low page select bit of the latch
    localparam int BANK_POS = 7;    // Bank bit inside the status word

    // Register byte offsets
    localparam logic [AXI_AW-1:0] OFS_PC_LOW  = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_LATCH   = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_POINTER = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_STATUS  = 8'h0c;

    // Reset values and interrupt vector
    localparam logic [PC_W-1:0]   RST_PC      = 13'h0000;
    localparam logic [HI_W-1:0]   RST_LATCH   = 5'h00;
    localparam logic [BYTE_W-1:0] RST_POINTER = 8'h00;
    localparam logic              RST_BANK    = 1'b0;
    localparam logic [PC_W-1:0]   IRQ_VECTOR  = 13'h0004;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Operations reported by the execution core
    typedef enum logic [2:0] {
        OP_STEP,
        OP_GOTO,
        OP_CALL,
        OP_RET,
        OP_IRQ,
        OP_PCL_WR
    } pcs_op_t;

endpackage

// ---- core/pcs_ret_stack.sv ----
// Circular hardware return stack
`timescale 1ns/1ps
module pcs_ret_stack #(
    parameter int DEPTH = pcs_pkg::STK_N,
    parameter int W     = pcs_pkg::PC_W
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         push,
    input  wire logic         pop,
    input  wire logic [W-1:0] push_data,
    output logic      [W-1:0] top_data
);
    import pcs_pkg::*;

    localparam int PW = $clog2(DEPTH);

    // Pointer and entries held as one state word
    typedef struct packed {
        logic [PW-1:0]             ptr;  // Next free slot
        logic [DEPTH-1:0][W-1:0]   ent;  // Stored return addresses
    } pcs_stk_state_t;

    pcs_stk_state_t           state_reg;   // Registered state
    pcs_stk_state_t           state_next;  // Next state
    logic [DEPTH-1:0][W-1:0]  ent_next;    // Per-entry next values
    logic [PW-1:0]            top_idx;     // Most recent entry

    // Pointer wraps, so the ninth push lands on the first slot
    // circular pointer wrap
    assign top_idx  = state_reg.ptr - 1'b1;
    assign top_data = state_reg.ent[top_idx];

    // Per-entry write select
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++)
        begin : g_ent
            assign ent_next[i] =
                (push && state_reg.ptr == PW'(i)) ?
                push_data : state_reg.ent[i];
        end
    endgenerate

    // Next state; overflow and underflow pass silently
    always_comb
    begin
        state_next     = state_reg;
        state_next.ent = ent_next;
        if (push)
            state_next.ptr = state_reg.ptr + 1'b1;
        else if (pop)
            state_next.ptr = top_idx;
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

endmodule // pcs_ret_stack

// ---- verification/pcs_sequencer_checker.sv ----
// Concurrent checks on the ports of the program sequencing block
`timescale 1ns/1ps
module pcs_sequencer_checker
    import pcs_pkg::*;
#(
    parameter logic [PC_W-1:0] IRQ_VEC = IRQ_VECTOR
) (
    input wire logic                       aclk,
    input wire logic                       aresetn,
    input wire logic                       exec_valid,
    input wire pcs_pkg::pcs_op_t           exec_op,
    input wire logic [pcs_pkg::TGT_W-1:0]  exec_target,
    input wire logic [pcs_pkg::BYTE_W-1:0] exec_data,
    input wire logic [pcs_pkg::PC_W-1:0]   pc_addr,
    input wire logic                       ind_valid,
    input wire logic                       ind_write,
    input wire logic [pcs_pkg::BYTE_W-1:0] ind_rdata,
    input wire logic                       ind_done,
    input wire logic [pcs_pkg::ADDR_W-1:0] mem_addr,
    input wire logic                       mem_we,
    input wire logic                       mem_re,
    input wire logic [pcs_pkg::BYTE_W-1:0] mem_rdata,
    input wire logic                       s_axi_rvalid,
    input wire logic [pcs_pkg::AXI_DW-1:0] s_axi_rdata
);
    // Single domain, so one clock and one disable serve all checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_pc_reset: assert property ($rose(aresetn) |-> pc_addr == 13'h0000)
        else $error("counter not clear after reset");
    chk_step_adv: assert property (exec_valid && exec_op == OP_STEP
        |=> pc_addr == $past(pc_addr) + 13'h0001) else $error("step wrong");
    chk_branch_low: assert property (exec_valid
        && exec_op inside {OP_GOTO, OP_CALL}
        |=> pc_addr[10:0] == $past(exec_target)) else $error("target wrong");
    chk_irq_vec: assert property (exec_valid && exec_op == OP_IRQ
        |=> pc_addr == IRQ_VEC) else $error("vector wrong");
    chk_pclwr_low: assert property (exec_valid && exec_op == OP_PCL_WR
        |=> pc_addr[7:0] == $past(exec_data)) else $error("low byte wrong");
    chk_call_ret: assert property (exec_valid && exec_op == OP_CALL
        ##1 exec_valid && exec_op == OP_RET
        |=> pc_addr == $past(pc_addr, 2) + 13'h0001) else $error("return wrong");
    chk_ind_answer: assert property (ind_valid |-> ##2 ind_done)
        else $error("indirect answer missing");
    chk_ind_data: assert property (mem_re |=> ind_done
        && ind_rdata == $past(mem_rdata)) else $error("indirect data wrong");
    chk_ind_zero: assert property (ind_valid && !ind_write ##1 !mem_re
        |=> ind_rdata == 8'h00) else $error("zero pointer read not zero");
    chk_ind_nowr: assert property (mem_we |-> mem_addr[7:0] != 8'h00)
        else $error("zero pointer write reached memory");
    chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule // pcs_sequencer_checker

bind pcs_sequencer pcs_sequencer_checker #(.IRQ_VEC(IRQ_VEC)) u_chk (.*);

// ---- verification/pcs_mem_model.sv ----
// Data memory seen through the indirect port
`timescale 1ns/1ps
module pcs_mem_model (
    input wire logic       aclk,
    input wire logic [8:0] mem_addr,
    input wire logic       mem_we,
    input wire logic       mem_re,
    input wire logic [7:0] mem_wdata,
    output logic     [7:0] mem_rdata
);
    logic [7:0] ram [512];
    logic [7:0] last = 8'h00;  // Last value driven, inverted when idle

    initial
    begin
        foreach (ram[i]) ram[i] = 8'(i) ^ 8'h5a;
    end

    // Writes land at the edge, so a following read sees them
    always @(posedge aclk)
    begin
        if (mem_we) ram[mem_addr] <= mem_wdata;
        if (mem_re) last <= ram[mem_addr];
    end

    // Data only valid while read strobe is high; otherwise it moves
    assign mem_rdata = mem_re ? ram[mem_addr] : ~last;
endmodule // pcs_mem_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the program sequencing block
`timescale 1ns/1ps
module tb_top;
    import pcs_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, pc_due = 1'b0, bank = 1'b0;
    logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [AXI_DW-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ind_done, mem_we, mem_re;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic exec_valid = 0, ind_valid = 0, ind_write = 0;
    pcs_op_t exec_op = OP_STEP;
    logic [TGT_W-1:0] exec_target = '0;
    logic [BYTE_W-1:0] exec_data = '0, ind_wdata = '0, ptr = '0;
    logic [BYTE_W-1:0] ind_rdata, mem_wdata, mem_rdata;
    logic [PC_W-1:0] pc_addr, pcm = '0;     // pcm is the expected counter
    logic [PC_W-1:0] stk [STK_N];           // Expected stack contents
    logic [ADDR_W-1:0] mem_addr;
    logic [2:0] sp = '0;                    // Wraps like the real stack
    logic [4:0] lat = '0;
    logic [7:0] shadow [512];
    logic [33:0] rq [$];                    // Expected {rresp, rdata}
    logic [1:0] bq [$];
    logic [12:0] pcq [$];
    logic [26:0] iq [$];  // {addr, we, wdata, compare, rdata}
    int err_total = 0, total_checks = 0;

    always #4 aclk = ~aclk;

    pcs_sequencer u_pcs_sequencer (.*);
    pcs_mem_model u_pcs_mem_model (.*);

    task automatic wrap_up;
        // A result that never came leaves its note behind
        if (pcq.size() + rq.size() + bq.size() + iq.size() != 0)
        begin
            err_total++;
            $display("unexpected pending notes: expected 0 seen %0d",
                     pcq.size() + rq.size() + bq.size() + iq.size());
        end
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(string what, logic [33:0] e, logic [33:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    task automatic no_answer(string what);
        err_total++;
        $display("unexpected %s: expected answer seen none", what);
        wrap_up();
    endtask

    // Register write; the expected model follows the register map
    task automatic bus_wr(logic [7:0] a, logic [7:0] d);
        int n;
        n = 0;
        bq.push_back(a < 8'h10 ? RESP_OKAY : RESP_DECERR);
        case (a)
            OFS_PC_LOW: pcm = {lat, d};
            OFS_LATCH: lat = d[4:0];
            OFS_POINTER: ptr = d;
            OFS_STATUS: bank = d[7];
            default: ;
        endcase
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 64);
        s_axi_bready <= 1'b0;
        if (!s_axi_bvalid) no_answer("bvalid");
    endtask

    // Register read; expectation noted before the request goes out
    task automatic bus_rd(logic [7:0] a);
        int n;
        n = 0;
        case (a)
            OFS_PC_LOW: rq.push_back({RESP_OKAY, 24'h0, pcm[7:0]});
            OFS_LATCH: rq.push_back({RESP_OKAY, 27'h0, lat});
            OFS_POINTER: rq.push_back({RESP_OKAY, 24'h0, ptr});
            OFS_STATUS: rq.push_back({RESP_OKAY, 24'h0, bank, 7'h0});
            default: rq.push_back({RESP_DECERR, 32'h0});
        endcase
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 64);
        s_axi_rready <= 1'b0;
        if (!s_axi_rvalid) no_answer("rvalid");
    endtask

    // One core operation; strobe left high so operations can abut
    task automatic op(pcs_op_t o, logic [10:0] t, logic [7:0] d);
        case (o)
            OP_STEP: pcm = pcm + 13'h1;
            OP_GOTO: pcm = {lat[4:3], t};
            OP_CALL:
            begin
                stk[sp] = pcm + 13'h1;
                sp = sp + 3'h1;
                pcm = {lat[4:3], t};
            end
            OP_RET:
            begin
                sp = sp - 3'h1;
                pcm = stk[sp];
            end
            OP_IRQ:
            begin
                stk[sp] = pcm;
                sp = sp + 3'h1;
                pcm = IRQ_VECTOR;
            end
            default: pcm = {lat, d};
        endcase
        pcq.push_back(pcm);
        @(posedge aclk);
        exec_valid <= 1'b1;
        exec_op <= o;
        exec_target <= t;
        exec_data <= d;
    endtask

    // Indirect access through pointer and bank bit
    task automatic ind(logic w, logic [7:0] d);
        if (w && ptr != 8'h00) shadow[{bank, ptr}] = d;
        // No strobe is due for pointer zero, so any strobe then mismatches
        iq.push_back({ptr == 8'h00 ? 18'h3ffff : {bank, ptr, w, w ? d : 8'h00},
                      !w, ptr == 8'h00 ? 8'h00 : shadow[{bank, ptr}]});
        @(posedge aclk);
        ind_valid <= 1'b1;
        ind_write <= w;
        ind_wdata <= d;
    endtask

    task automatic idle;
        @(posedge aclk);
        exec_valid <= 1'b0;
        ind_valid <= 1'b0;
    endtask

    // Results are matched in arrival order against the noted ones
    always @(posedge aclk)
    begin
        pc_due <= exec_valid && aresetn;
        if (pc_due)
            cmp("pc_addr", 34'(pcq.size() ? pcq.pop_front() : 'x), 34'(pc_addr));
        if (s_axi_bvalid && s_axi_bready)
            cmp("bresp", 34'(bq.size() ? bq.pop_front() : 'x), 34'(s_axi_bresp));
        if (s_axi_rvalid && s_axi_rready)
            cmp("rdata", rq.size() ? rq.pop_front() : 'x, {s_axi_rresp, s_axi_rdata});
        if (ind_done && iq.size() == 0)
            cmp("ind_done", 34'h0, 34'h1);
        if (ind_done && iq.size() != 0 && iq[0][8])
            cmp("ind_rdata", 34'(iq[0][7:0]), 34'(ind_rdata));
        if (ind_done && iq.size() != 0) void'(iq.pop_front());
        // Strobes belong to the oldest request still unanswered
        if ((mem_we || mem_re) && iq.size() != 0)
            cmp("mem_access", 34'(iq[0][26:9]),
                34'({mem_addr, mem_we, mem_we ? mem_wdata : 8'h00}));
    end

    initial
    begin
        foreach (stk[i]) stk[i] = '0;
        void'($urandom(12));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) bus_rd(8'(i * 4));
        bus_wr(OFS_LATCH, 8'hff);
        bus_wr(OFS_STATUS, 8'hff);
        bus_wr(OFS_PC_LOW, 8'hff);
        bus_wr(8'h14, 8'h33);
        for (int i = 0; i < 5; i++) bus_rd(8'(i * 4));
        op(OP_STEP, 11'h0, 8'h0);
        op(OP_PCL_WR, 11'h0, 8'h05);
        idle();
        $display("test registers done");
        for (int i = 0; i < 9; i++) op(OP_CALL, 11'(i * 8 + 1), 8'h0);
        op(OP_RET, 11'h0, 8'h0);
        idle();
        bus_rd(OFS_LATCH);
        bus_wr(OFS_LATCH, 8'h00);
        for (int i = 0; i < 9; i++) op(OP_RET, 11'h0, 8'h0);
        op(OP_IRQ, 11'h0, 8'h0);
        op(OP_RET, 11'h0, 8'h0);
        for (int p = 0; p < 4; p++)
        begin
            idle();
            bus_wr(OFS_LATCH, 8'(p * 8));
            op(OP_GOTO, 11'h7ff, 8'h0);
        end
        for (int i = 0; i < 300; i++)
        begin
            if (i % 20 == 0) idle();
            if (i % 20 == 0) bus_wr(OFS_LATCH, 8'($urandom));
            op(pcs_op_t'(3'($urandom_range(5, 0))), 11'($urandom), 8'($urandom));
        end
        idle();
        $display("test sequencing done");
        // Mid-run reset from a non-zero counter, latch and stack
        bus_wr(OFS_LATCH, 8'h1f);
        op(OP_PCL_WR, 11'h0, 8'h80);
        idle();
        aresetn <= 1'b0;
        {pcm, lat, ptr, bank, sp} = 30'h0;
        foreach (stk[i]) stk[i] = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        op(OP_STEP, 11'h0, 8'h0);
        op(OP_RET, 11'h0, 8'h0);
        idle();
        bus_rd(OFS_LATCH);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            bus_wr(OFS_POINTER, i < 2 ? 8'h00 : 8'($urandom_range(255, 1)));
            bus_wr(OFS_STATUS, {i[0], 7'h0});
            ind(1'b1, 8'($urandom));
            ind(1'b0, 8'h00);
            ind(1'b0, 8'h00);
            idle();
        end
        repeat (4) @(posedge aclk);
        $display("test indirect done");
        wrap_up();
    end
endmodule // tb_top
